//--- verilog/ccr_pkg.sv
// Package with register map, reset values and field positions of the charger config registers
package ccr_pkg;

    // ==========================================================
    // Bus geometry
    // ==========================================================
    localparam int unsigned CCR_DATA_W = 32;
    localparam int unsigned CCR_IDX_W = 6;
    localparam int unsigned CCR_IDX_LSB = 2;

    // ==========================================================
    // Register indices (byte address is four times the index)
    // ==========================================================
    localparam logic [5:0] CCR_IDX_CONFIG_ONE = 6'h04;
    localparam logic [5:0] CCR_IDX_CONFIG_TWO = 6'h05;
    localparam logic [5:0] CCR_IDX_STATUS = 6'h10;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] CCR_CONFIG_ONE_RST = 8'h01;
    localparam logic [7:0] CCR_CONFIG_TWO_RST = 8'h80;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int unsigned CCR_POS_CHARGER_ON = 0;
    localparam int unsigned CCR_POS_SLOWDOWN = 7;
    localparam int unsigned CCR_POS_PRECHARGE = 6;
    localparam int unsigned CCR_POS_VOLT_HI = 5;
    localparam int unsigned CCR_POS_VOLT_LO = 4;
    localparam int unsigned CCR_POS_STS_THERMAL = 0;
    localparam int unsigned CCR_POS_STS_PATH = 1;
    localparam int unsigned CCR_POS_STS_SLOW = 2;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned CCR_SLOW_DIVIDE = 2;
    localparam int unsigned CCR_SYNC_STAGES = 2;

endpackage : ccr_pkg

//--- verilog/ccr_tick_div.sv
// Safety-timer tick gate that passes every tick or every second tick
`timescale 1ns/10ps
module ccr_tick_div
    import ccr_pkg::*;
(
    input wire logic pclk, // Register clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic tick_in, // Nominal safety-timer tick, one-cycle pulse
    input wire logic slow_en, // Halve the tick rate while high
    output logic tick_out // Gated tick, one-cycle pulse
);

    typedef struct packed {
        logic phase;
        logic tick;
    } ccr_div_state_t;

    ccr_div_state_t st_q;
    ccr_div_state_t st_d;

    // Elaboration check: the gate only knows how to halve the rate
    if (CCR_SLOW_DIVIDE != 2) begin : g_bad_divide
        $error("Only a divide by two is supported");
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (tick_in) begin
            if (!slow_en) begin
                st_d.tick = 1'b1;
                st_d.phase = 1'b0;
            end else begin
                st_d.tick = st_q.phase;
                st_d.phase = ~st_q.phase;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick_out = st_q.tick;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking div_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    nominal_pass_a: assert property (tick_in && !slow_en |=> tick_out)
        else $error("Tick dropped at nominal rate");
    slow_skip_a: assert property (tick_in && slow_en && !st_q.phase |=> !tick_out)
        else $error("First slow tick not swallowed");
    slow_pass_a: assert property (tick_in && slow_en && st_q.phase |=> tick_out)
        else $error("Second slow tick not passed");
    no_spurious_a: assert property (!tick_in |=> !tick_out)
        else $error("Tick without source tick");

endmodule : ccr_tick_div

//--- verilog/ccr_regs.sv
// APB register bank for charger enable and second charger configuration register
//
// Summary of operation
// - Charger enable resets to one, writable.
// - Config two at index 0x05, resets 0x80.
// - Slowdown bit zero: timers at nominal rate.
// - Slowdown bit one: halve rate when loop active.
// - Bit 6 picks precharge threshold, reset zero.
// - Bits 5:4 pick charge voltage, reset 00.
// - Bits 3:0 plain storage, reset zero.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
module ccr_regs
    import ccr_pkg::*;
#(
    parameter int unsigned ADDR_W = 8 // APB address width
) (
    input wire logic pclk, // Register clock, 40 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, high for write
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic thermal_loop_active, // Thermal loop active, asynchronous level
    input wire logic power_path_loop_active, // Power-path loop active, asynchronous level
    input wire logic timer_tick_in, // Nominal safety-timer tick, same clock
    output logic safety_tick, // Safety-timer tick after scaling
    output logic charger_on, // Charger enable
    output logic timer_slowdown_sel, // Dynamic timer scaling select
    output logic precharge_threshold_sel, // 0 selects 2.9 V, 1 selects 2.5 V
    output logic [1:0] charge_voltage_sel // 4.1 / 4.15 / 4.2 / 4.2 V
);

    typedef struct packed {
        logic charger_on;
        logic [7:0] config_two;
        logic [CCR_SYNC_STAGES-1:0] thermal_sync;
        logic [CCR_SYNC_STAGES-1:0] path_sync;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic seen_write;
    } ccr_state_t;

    ccr_state_t st_q;
    ccr_state_t st_d;

    logic [CCR_IDX_W-1:0] idx;
    logic aligned;
    logic mapped;
    logic wr_take;
    logic slow_active;
    logic [31:0] rd_value;

    // Elaboration check: the decode needs the full index above the byte lanes
    if (ADDR_W < CCR_IDX_W + CCR_IDX_LSB) begin : g_bad_addr
        $error("Address too narrow for the register map");
    end

    // ==========================================================
    // Address decode
    // ==========================================================
    assign idx = paddr[CCR_IDX_W+CCR_IDX_LSB-1:CCR_IDX_LSB];
    assign aligned = (paddr[CCR_IDX_LSB-1:0] == 2'h0)
        && ((ADDR_W == CCR_IDX_W + CCR_IDX_LSB)
        || (paddr >> (CCR_IDX_W + CCR_IDX_LSB)) == '0);
    assign mapped = aligned && ((idx == CCR_IDX_CONFIG_ONE)
        || (idx == CCR_IDX_CONFIG_TWO) || (idx == CCR_IDX_STATUS));
    assign wr_take = psel && penable && pwrite && st_q.pready && mapped;

    assign slow_active = st_q.config_two[CCR_POS_SLOWDOWN]
        && (st_q.thermal_sync[CCR_SYNC_STAGES-1] || st_q.path_sync[CCR_SYNC_STAGES-1]);

    // ==========================================================
    // Read mux
    // ==========================================================
    always_comb begin
        rd_value = 32'h0000_0000;
        if (aligned) begin
            case (idx)
                CCR_IDX_CONFIG_ONE: begin
                    rd_value[CCR_POS_CHARGER_ON] = st_q.charger_on;
                end
                CCR_IDX_CONFIG_TWO: begin
                    rd_value[7:0] = st_q.config_two;
                end
                CCR_IDX_STATUS: begin
                    rd_value[CCR_POS_STS_THERMAL] = st_q.thermal_sync[CCR_SYNC_STAGES-1];
                    rd_value[CCR_POS_STS_PATH] = st_q.path_sync[CCR_SYNC_STAGES-1];
                    rd_value[CCR_POS_STS_SLOW] = slow_active;
                end
                default: begin
                    rd_value = 32'h0000_0000;
                end
            endcase
        end
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        st_d = st_q;
        st_d.thermal_sync = {st_q.thermal_sync[CCR_SYNC_STAGES-2:0], thermal_loop_active};
        st_d.path_sync = {st_q.path_sync[CCR_SYNC_STAGES-2:0], power_path_loop_active};
        // One wait state: ready rises in the second access cycle
        st_d.pready = psel && penable && !st_q.pready;
        st_d.pslverr = psel && penable && !st_q.pready && !mapped;
        if (psel && penable && !st_q.pready) begin
            st_d.prdata = pwrite ? 32'h0000_0000 : rd_value;
        end
        if (wr_take) begin
            st_d.seen_write = 1'b1;
            if (idx == CCR_IDX_CONFIG_ONE) begin
                st_d.charger_on = pwdata[CCR_POS_CHARGER_ON];
            end
            if (idx == CCR_IDX_CONFIG_TWO) begin
                st_d.config_two = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.charger_on <= CCR_CONFIG_ONE_RST[CCR_POS_CHARGER_ON];
            st_q.config_two <= CCR_CONFIG_TWO_RST;
            st_q.thermal_sync <= '0;
            st_q.path_sync <= '0;
            st_q.pready <= 1'b0;
            st_q.pslverr <= 1'b0;
            st_q.prdata <= 32'h0000_0000;
            st_q.seen_write <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Safety-timer tick scaling
    // ==========================================================
    ccr_tick_div u_tick_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick_in(timer_tick_in),
        .slow_en(slow_active),
        .tick_out(safety_tick)
    );

    // ==========================================================
    // Outputs
    // ==========================================================
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign charger_on = st_q.charger_on;
    assign timer_slowdown_sel = st_q.config_two[CCR_POS_SLOWDOWN];
    assign precharge_threshold_sel = st_q.config_two[CCR_POS_PRECHARGE];
    assign charge_voltage_sel = st_q.config_two[CCR_POS_VOLT_HI:CCR_POS_VOLT_LO];

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking regs_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    reset_values_a: assert property (
        !st_q.seen_write |-> charger_on && st_q.config_two == CCR_CONFIG_TWO_RST)
        else $error("Reset values wrong before first write");

    enable_write_a: assert property (
        wr_take && idx == CCR_IDX_CONFIG_ONE
        |=> charger_on == $past(pwdata[CCR_POS_CHARGER_ON]))
        else $error("Charger enable did not take written value");

    precharge_write_a: assert property (
        wr_take && idx == CCR_IDX_CONFIG_TWO
        |=> precharge_threshold_sel == $past(pwdata[CCR_POS_PRECHARGE]))
        else $error("Precharge threshold select not updated");

    voltage_write_a: assert property (
        wr_take && idx == CCR_IDX_CONFIG_TWO
        |=> charge_voltage_sel == $past(pwdata[CCR_POS_VOLT_HI:CCR_POS_VOLT_LO]))
        else $error("Charge voltage select not updated");

    reserved_store_a: assert property (
        wr_take && idx == CCR_IDX_CONFIG_TWO ##1 !(wr_take && idx == CCR_IDX_CONFIG_TWO)
        |=> st_q.config_two[3:0] == $past(pwdata[3:0], 2))
        else $error("Reserved bits not stored");

    readback_a: assert property (
        psel && penable && !pwrite && pready && aligned && idx == CCR_IDX_CONFIG_TWO
        |-> prdata == {24'h00_0000, st_q.config_two})
        else $error("Read of config two differs from stored byte");

    nominal_rate_a: assert property (!timer_slowdown_sel && timer_tick_in |=> safety_tick)
        else $error("Tick lost with slowdown off");

    slowdown_gate_a: assert property (
        timer_slowdown_sel && thermal_loop_active && !power_path_loop_active [*3]
        |-> slow_active)
        else $error("Slowdown not active with thermal loop on");

    one_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("Ready not after one wait state");

    unmapped_err_a: assert property (psel && penable && pready |-> pslverr == !mapped)
        else $error("Error answer mismatches decode");

    write_cfg_c: cover property (wr_take && idx == CCR_IDX_CONFIG_TWO);
    disable_chg_c: cover property (wr_take && idx == CCR_IDX_CONFIG_ONE && !pwdata[0]);
    slow_tick_c: cover property (slow_active && timer_tick_in ##[1:20] slow_active && safety_tick);
    unmapped_c: cover property (pready && pslverr);

endmodule : ccr_regs

//--- verification/tb_top.sv
// Self-checking bench for the charger configuration register bank
`timescale 1ns/10ps
module tb_top
    import ccr_pkg::*;
;
    // ==========================================================
    // Clock, reset and stimulus signals
    // ==========================================================
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic thermal = 1'b0;
    logic path = 1'b0;
    logic tick_in = 1'b0;
    logic safety_tick;
    logic charger_on;
    logic slow_sel;
    logic pre_sel;
    logic [1:0] volt_sel;
    int err_count = 0;
    int checks_done = 0;
    int ticks_seen = 0;
    localparam logic [7:0] ADDR_ONE = {CCR_IDX_CONFIG_ONE, 2'b00};
    localparam logic [7:0] ADDR_TWO = {CCR_IDX_CONFIG_TWO, 2'b00};
    localparam logic [7:0] ADDR_STS = {CCR_IDX_STATUS, 2'b00};

    always #12.5 pclk = ~pclk;

    always @(posedge pclk) if (safety_tick === 1'b1) ticks_seen++;

    ccr_regs #(.ADDR_W(8)) u_ccr_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .thermal_loop_active(thermal),
        .power_path_loop_active(path), .timer_tick_in(tick_in),
        .safety_tick(safety_tick), .charger_on(charger_on),
        .timer_slowdown_sel(slow_sel), .precharge_threshold_sel(pre_sel),
        .charge_voltage_sel(volt_sel)
    );

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Ready, data and error are taken at the rising edge that sees ready high
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk(32'h0, 32'h1, "apb timeout");
            complete_run();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    // Sends n ticks two cycles apart and counts the gated ticks
    task automatic ticks(input int n, input int exp);
        int base = ticks_seen;
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            tick_in <= 1'b1;
            @(posedge pclk);
            tick_in <= 1'b0;
        end
        repeat (3) @(posedge pclk);
        chk(ticks_seen - base, exp, "tick count");
    endtask : ticks

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic reset_values();
        logic [31:0] rd;
        logic er;
        @(negedge pclk);
        chk(32'(charger_on), 32'h1, "enable out");
        chk(32'({slow_sel, pre_sel, volt_sel}), 32'h8, "config outs");
        apb(1'b0, ADDR_TWO, 32'h0, rd, er);
        chk(rd, 32'h80, "config two reset");
        apb(1'b0, ADDR_ONE, 32'h0, rd, er);
        chk(rd, 32'h1, "enable reset");
    endtask : reset_values

    task automatic reset_midrun();
        logic [31:0] rd;
        logic er;
        apb(1'b1, ADDR_ONE, 32'h0, rd, er);
        apb(1'b1, ADDR_TWO, 32'h7F, rd, er);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        reset_values();
    endtask : reset_midrun

    task automatic enable_toggle();
        logic [31:0] rd;
        logic er;
        apb(1'b1, ADDR_ONE, 32'h0, rd, er);
        @(negedge pclk);
        chk(32'(charger_on), 32'h0, "charger off");
        apb(1'b0, ADDR_ONE, 32'h0, rd, er);
        chk(rd, 32'h0, "enable read off");
        apb(1'b1, ADDR_ONE, 32'h1, rd, er);
        @(negedge pclk);
        chk(32'(charger_on), 32'h1, "charger on");
    endtask : enable_toggle

    task automatic field_codes();
        logic [7:0] vals [4] = '{8'h0F, 8'h5A, 8'hA5, 8'h3C};
        logic [31:0] rd;
        logic er;
        foreach (vals[i]) begin
            apb(1'b1, ADDR_TWO, {24'hFFFFFF, vals[i]}, rd, er);
            @(negedge pclk);
            chk(32'({slow_sel, pre_sel, volt_sel}), 32'(vals[i][7:4]), "fields");
            apb(1'b0, ADDR_TWO, 32'h0, rd, er);
            chk(rd, {24'h0, vals[i]}, "readback");
        end
    endtask : field_codes

    task automatic unmapped();
        logic [31:0] rd;
        logic er;
        apb(1'b1, 8'h20, 32'hFF, rd, er);
        chk(32'(er), 32'h1, "unmapped write error");
        apb(1'b0, 8'h20, 32'h0, rd, er);
        chk(32'(er), 32'h1, "unmapped read error");
        chk(rd, 32'h0, "unmapped read data");
        apb(1'b1, 8'h15, 32'hFF, rd, er);
        chk(32'(er), 32'h1, "misaligned write error");
        apb(1'b0, ADDR_TWO, 32'h0, rd, er);
        chk(32'(er), 32'h0, "config read error");
        chk(rd, 32'h3C, "config kept");
    endtask : unmapped

    task automatic tick_scaling();
        logic [31:0] rd;
        logic er;
        thermal <= 1'b1;
        apb(1'b1, ADDR_TWO, 32'h00, rd, er);
        repeat (4) @(posedge pclk);
        ticks(4, 4);
        apb(1'b1, ADDR_TWO, 32'h80, rd, er);
        repeat (4) @(posedge pclk);
        apb(1'b0, ADDR_STS, 32'h0, rd, er);
        chk(rd, 32'h5, "slowdown status");
        ticks(4, 2);
        thermal <= 1'b0;
        path <= 1'b1;
        repeat (4) @(posedge pclk);
        ticks(4, 2);
        path <= 1'b0;
        repeat (4) @(posedge pclk);
        ticks(4, 4);
    endtask : tick_scaling

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        reset_values();
        enable_toggle();
        field_codes();
        unmapped();
        tick_scaling();
        reset_midrun();
        complete_run();
    end
endmodule : tb_top
